// *** dv/drvspi_host.sv ***
// Host serial master model that runs frames on the device link
`timescale 1ns/1ps
`default_nettype none
module drvspi_host (
  output logic      spi_clk,
  output logic      frame_select_n,
  output logic      serial_in_pin,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  logic ff_seen;

  initial begin
    spi_clk        = 1'b0;
    frame_select_n = 1'b0;
    serial_in_pin  = 1'b0;
    ff_seen        = 1'b0;
    // Early rising select clears the frame-local link state
    #2 frame_select_n = 1'b1;
  end

  // One frame of nclk clocks, 32 ns link period; bit 0 of w selects the word
  task automatic frame(input logic [15:0] w, input int nclk, output logic [15:0] rx);
    rx             = 16'h0000;
    frame_select_n = 1'b0;
    #16 ff_seen    = serial_out_oe ? serial_out : 1'bz;
    for (int i = 0; i < nclk; i++) begin
      serial_in_pin = w[i % 16];
      #8 spi_clk = 1'b1;
      #8 if (i == 0) rx[0] = serial_out;
      #8 spi_clk = 1'b0;
      #8 if (i < 15) rx[i+1] = serial_out;
    end
    #16 frame_select_n = 1'b1;
    // Released data line shows no stale level
    serial_in_pin = ~serial_in_pin;
    #450;
  endtask
endmodule // drvspi_host
`default_nettype wire

// *** dv/drvspi_top_tb.sv ***
// Self-checking bench of the driver serial control block
`timescale 1ns/1ps
`default_nettype none
module drvspi_top_tb;
  import drvspi_pkg::*;
  localparam int SU = 100;
  logic                core_clk;
  logic                reset_n;
  logic                pwm_in_pin;
  logic                active_mode;
  drvspi_sense_s       sense;
  wire                 spi_clk;
  wire                 frame_select_n;
  wire                 serial_in_pin;
  logic                serial_out;
  logic                serial_out_oe;
  logic [NSTAGE-1:0]   stage_on;
  logic [NOUT-1:0]     current_image_out;
  logic [15:0]         rx;
  int                  n_fail;
  int                  n_tests;
  int                  cyc;

  drvspi_top #(.STARTUP_CYCLES(SU), .RETRY_TICK(2)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .spi_clk(spi_clk),
    .frame_select_n(frame_select_n), .serial_in_pin(serial_in_pin),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .pwm_in_pin(pwm_in_pin),
    .active_mode(active_mode), .sense(sense), .stage_on(stage_on),
    .current_image_out(current_image_out)
  );

  drvspi_host host (
    .spi_clk(spi_clk), .frame_select_n(frame_select_n), .serial_in_pin(serial_in_pin),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe)
  );

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  task automatic close_out();
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(input logic [15:0] w);
    host.frame(w, 16, rx);
    wt(12);
  endtask

  task automatic rd(input logic [15:0] w, input logic [15:0] exp);
    host.frame(w, 16, rx);
    wt(2);
    chk(rx, exp);
  endtask

  // Conducting cycles of the last stage over two retry periods
  task automatic t_count(input logic [15:0] exp);
    int n;
    n = 0;
    repeat (32) begin
      @(negedge core_clk);
      n += int'(stage_on[7]);
    end
    chk(16'(n), exp);
  endtask

  task automatic t_start();
    chk(16'(serial_out_oe), 16'h0000);
    active_mode = 1'b1;
    // Start-up state must reach the frozen status copy first
    wt(8);
    rd(16'h0001, 16'h8400);
    chk(16'(host.ff_seen), 16'h0000);
    wr(16'h0100);
    chk(16'(stage_on), 16'h0000);
    wt(SU);
    chk(16'(stage_on), 16'h0080);
    rd(16'h0001, 16'h8001);
    chk(16'(host.ff_seen), 16'h0001);
  endtask

  task automatic t_monitor();
    for (int c = 0; c < 8; c++) begin
      wr(16'(c << 9) | 16'h0052);
      chk(16'(stage_on), 16'h0029);
      chk(16'(current_image_out), (c < 5) ? 16'(1 << c) : 16'h0000);
    end
    wr(16'h01FE);
    chk(16'(stage_on), 16'h00C0);
    host.frame(16'h0000, 15, rx);
    wt(12);
    chk(16'(stage_on), 16'h00C0);
    host.frame(16'h0000, 17, rx);
    wt(12);
    chk(16'(stage_on), 16'h00C0);
  endtask

  task automatic t_overcurrent();
    sense.oc[7] = 1'b1;
    wt(4);
    sense.oc[7] = 1'b0;
    wt(4);
    chk(16'(stage_on), 16'h0040);
    wt(20);
    chk(16'(stage_on), 16'h0040);
    rd(16'h01FE, 16'h8100);
    host.frame(16'h81FE, 17, rx);
    wt(12);
    chk(16'(stage_on), 16'h0040);
    wr(16'h81FE);
    chk(16'(stage_on), 16'h00C0);
    rd(16'h01FE, 16'h8001);
  endtask

  task automatic t_supply();
    sense.uv = 1'b1;
    wt(4);
    chk(16'(stage_on), 16'h0000);
    sense.uv = 1'b0;
    wt(6);
    chk(16'(stage_on), 16'h00C0);
    wr(16'h91FE);
    chk(16'(stage_on), 16'h00C0);
    sense.ov = 1'b1;
    wt(4);
    sense.ov = 1'b0;
    wt(6);
    chk(16'(stage_on), 16'h0000);
    rd(16'h0001, 16'hC000);
    wr(16'h81FE);
    chk(16'(stage_on), 16'h00C0);
  endtask

  task automatic t_thermal();
    sense.tw = 1'b1;
    wt(4);
    chk(16'(stage_on), 16'h00C0);
    sense.thermal_trip_flag = 1'b1;
    wt(4);
    sense.thermal_trip_flag = 1'b0;
    wt(6);
    chk(16'(stage_on), 16'h0000);
    rd(16'h0001, 16'h9800);
    sense.tw = 1'b0;
    wr(16'h81FE);
    chk(16'(stage_on), 16'h00C0);
  endtask

  task automatic t_open_load();
    sense.ol[0] = 1'b1;
    wt(4);
    sense.ol[0] = 1'b0;
    rd(16'h41FE, 16'h8000);
    rd(16'h41FE, 16'h8001);
    rd(16'h0001, 16'h8003);
    wr(16'h81FE);
  endtask

  task automatic t_pwm();
    wr(16'h0401);
    chk(16'(stage_on), 16'h0040);
    pwm_in_pin = 1'b1;
    wt(6);
    chk(16'(stage_on), 16'h00C0);
  endtask

  task automatic t_retry();
    wr(16'h0021);
    sense.oc[7] = 1'b1;
    wt(2);
    sense.oc[7] = 1'b0;
    wt(2);
    t_count(16'h0004);
    wr(16'h21FE);
    t_count(16'h0008);
    wr(16'h81FE);
    chk(16'(stage_on), 16'h00C0);
  endtask

  initial begin
    n_fail      = 0;
    n_tests     = 0;
    cyc         = 0;
    reset_n     = 1'b1;
    pwm_in_pin  = 1'b0;
    active_mode = 1'b0;
    sense       = '0;
    rx          = 16'h0000;
    // Clean falling reset edge clears every flip-flop at once except loaded_r, out_word_r and out_idx_r, which only select clears
    #1 reset_n  = 1'b0;
    repeat (5) @(negedge core_clk);
    reset_n = 1'b1;
    wt(8);
    t_start();
    t_monitor();
    t_overcurrent();
    t_supply();
    t_thermal();
    t_open_load();
    t_pwm();
    t_retry();
    close_out();
  end
endmodule // drvspi_top_tb
`default_nettype wire

// *** rtl/drvspi_pkg.sv ***
// Constants, field layout and carrier types of the driver serial control block
package drvspi_pkg;
  localparam int WORD_W = 16;
  localparam int NSTAGE = 8;
  localparam int NOUT   = 5;
  localparam int NHB    = 3;
  // Control word zero fields
  localparam int C_SEL   = 0;
  localparam int C_DRV   = 1;
  localparam int C_CM    = 9;
  localparam int C_UVDIS = 12;
  localparam int C_RATIO = 13;
  localparam int C_NOOL  = 14;
  localparam int C_RST   = 15;
  // Control word one fields
  localparam int C_REC   = 1;
  localparam int C_PWM   = 6;
  // Status word fields
  localparam int S_FF    = 0;
  localparam int S_OC    = 1;
  localparam int S_OL    = 1;
  localparam int S_NR    = 10;
  localparam int S_TW    = 11;
  localparam int S_TSD   = 12;
  localparam int S_UV    = 13;
  localparam int S_OV    = 14;
  localparam int S_ONE   = 15;
  // Reset values and counts
  localparam logic [15:0] CTRL_RST     = 16'h0000;
  localparam logic [4:0]  FRAME_BITS   = 5'h10;
  localparam logic [4:0]  CNT_SAT      = 5'h11;
  localparam logic [2:0]  CM_LAST      = 3'h4;
  localparam int          STARTUP_DEF  = 1000;
  localparam int          RETRY_TICK_DEF = 16;
  // Output index of each stage, stage 0 at the low end
  localparam logic [23:0] STAGE_OUT = {3'h4, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};

  typedef enum logic [2:0] {
    PWR_STANDBY = 3'b001,
    PWR_STARTUP = 3'b010,
    PWR_ACTIVE  = 3'b100
  } drvspi_pwr_e;

  typedef struct packed {
    logic [7:0] oc;
    logic [7:0] ol;
    logic       ov;
    logic       uv;
    logic       thermal_trip_flag;
    logic       tw;
  } drvspi_sense_s;

  typedef struct packed {
    logic [15:0] w1;
    logic [15:0] w0;
  } drvspi_stat_s;
endpackage

// *** rtl/drvspi_top.sv ***
// Serial control and status interface of a multi-output load driver
// How it works
// - Output floats while select high; shows fault-free bit once select falls.
// - First rising clock edge of a frame loads the chosen status word.
// - Each later falling clock edge moves the next status bit out.
// - Input sampled on rising edges; host holds data and samples after falls.
// - First received bit picks which control word is written.
// - Select rising commits the word only after exactly sixteen clocks.
// - That same first bit picks which status word goes out.
// - Control bits one to eight switch the eight driver stages on.
// - Bits nine to eleven route one of five high sides to monitor.
// - Committed reset bit clears every status flag but not-ready at frame end.
// - Status bit zero is NOR of flag bits one to fourteen.
// - A set over-current flag switches its stage off.
// - Without recovery, an over-current stage stays off until flag cleared.
// - Status bit fifteen always reads one.
// - Control bit fourteen drops open-load flags from fault summary.
// - Control bit thirteen picks one-eighth or one-quarter retry on-time.
// - Control bit twelve keeps outputs off after supply fault until cleared.
// - Over- or under-voltage sets its flag and disables outputs.
// - Otherwise outputs return by themselves when supply is normal.
// - Thermal trip sets bit twelve, all stages off until cleared.
// - Temperature warning only reports, never switches outputs.
// - Leaving standby sets not-ready, blocks outputs until timer expires.
// - Words travel least significant bit first both ways.
// - With PWM enabled a stage conducts only while PWM input high.
// - High and low side of one half bridge never conduct together.
// - Each over-current event sets its own flag in status word zero.
`timescale 1ns/1ps
`default_nettype none
module drvspi_top #(
  parameter int STARTUP_CYCLES = drvspi_pkg::STARTUP_DEF,
  parameter int RETRY_TICK     = drvspi_pkg::RETRY_TICK_DEF
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic                    spi_clk,
  input  wire logic                    frame_select_n,
  input  wire logic                    serial_in_pin,
  output logic                         serial_out,
  output logic                         serial_out_oe,
  input  wire logic                    pwm_in_pin,
  input  wire logic                    active_mode,
  input  wire drvspi_pkg::drvspi_sense_s sense,
  output logic [drvspi_pkg::NSTAGE-1:0] stage_on,
  output logic [drvspi_pkg::NOUT-1:0]   current_image_out
);
  import drvspi_pkg::*;

  logic [1:0]          rst_sync_r;
  logic                rst_n;
  logic [3:0]          sy1_r;
  logic [3:0]          sy2_r;
  logic [3:0]          sy3_r;
  logic [3:0]          syq_r;
  logic                csn_prev_r;
  logic                seen_tgl_r;
  logic                frame_end;
  logic                frame_ok;
  logic                commit0;
  logic                commit1;
  logic                clr_flags;
  logic [15:0]         ctrl0_r;
  logic [15:0]         ctrl1_r;
  logic [7:0]          oc_flag_r;
  logic [7:0]          ol_flag_r;
  logic                ov_r;
  logic                uv_r;
  logic                tsd_r;
  logic                tw_r;
  logic                nr_flag;
  drvspi_stat_s        stat;
  drvspi_stat_s        hold_r;
  logic                fault_free;
  drvspi_pwr_e         pwr_r;
  logic                act_prev_r;
  logic [31:0]         su_cnt_r;
  logic [31:0]         tick_cnt_r;
  logic [2:0]          phase_r;
  logic                retry_win;
  logic                global_off;
  logic [7:0]          want;
  logic [7:0]          drv_nxt;
  logic [7:0]          drv_on_r;
  logic [4:0]          cm_r;
  // Link-side state
  logic [15:0]         shift_in_r;
  logic [4:0]          cnt_r;
  logic                loaded_r;
  logic                start_tgl_r;
  logic [15:0]         out_word_r;
  logic [3:0]          out_idx_r;

  // Reset release
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rst_sync_r <= 2'b00;
    else          rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ---------------- Link domain ----------------
  // Shift in on rising edges, first bit lands at bit zero
  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_in_r <= 16'h0000;
      cnt_r      <= 5'h00;
    end else begin
      shift_in_r <= {serial_in_pin, shift_in_r[15:1]};
      if (!loaded_r) cnt_r <= 5'h01;
      else if (cnt_r != CNT_SAT) cnt_r <= cnt_r + 5'h01;
    end
  end

  // First edge of frame loads the status word chosen by the first bit
  always_ff @(posedge spi_clk or posedge frame_select_n) begin
    if (frame_select_n) begin
      loaded_r   <= 1'b0;
      out_word_r <= 16'h0000;
    end else if (!loaded_r) begin
      loaded_r   <= 1'b1;
      out_word_r <= serial_in_pin ? hold_r.w1 : hold_r.w0;
    end
  end

  // Frame start event toward the core
  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n)         start_tgl_r <= 1'b0;
    else if (!loaded_r) start_tgl_r <= ~start_tgl_r;
  end

  // Falling edges step through the loaded word
  always_ff @(negedge spi_clk or posedge frame_select_n) begin
    if (frame_select_n) out_idx_r <= 4'h0;
    else if (loaded_r)  out_idx_r <= out_idx_r + 4'h1;
  end

  assign serial_out_oe = ~frame_select_n;
  assign serial_out    = loaded_r ? out_word_r[out_idx_r] : hold_r.w0[S_FF];

  // ---------------- Core domain ----------------
  // Pins and link events: select, PWM, start toggle, active mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_r <= 4'b0001;
      sy2_r <= 4'b0001;
      sy3_r <= 4'b0001;
      syq_r <= 4'b0001;
    end else begin
      sy1_r <= {active_mode, start_tgl_r, pwm_in_pin, frame_select_n};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      syq_r <= (sy2_r & ~(sy2_r ^ sy3_r)) | (syq_r & (sy2_r ^ sy3_r));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      csn_prev_r <= 1'b1;
      seen_tgl_r <= 1'b0;
    end else begin
      csn_prev_r <= syq_r[0];
      if (frame_end) seen_tgl_r <= syq_r[2];
    end
  end

  // Link counters are quiet while select is high, so read directly here
  assign frame_end = syq_r[0] & ~csn_prev_r;
  assign frame_ok  = frame_end & (syq_r[2] != seen_tgl_r) & (cnt_r == FRAME_BITS);
  assign commit0   = frame_ok & ~shift_in_r[C_SEL];
  assign commit1   = frame_ok &  shift_in_r[C_SEL];
  assign clr_flags = commit0 & shift_in_r[C_RST];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_r <= CTRL_RST;
      ctrl1_r <= CTRL_RST;
    end else begin
      if (commit0) ctrl0_r <= shift_in_r;
      if (commit1) ctrl1_r <= shift_in_r;
    end
  end

  // Sticky flags, a new event beats the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_flag_r <= 8'h00;
      ol_flag_r <= 8'h00;
      ov_r      <= 1'b0;
      uv_r      <= 1'b0;
      tsd_r     <= 1'b0;
      tw_r      <= 1'b0;
    end else begin
      oc_flag_r <= sense.oc | (oc_flag_r & {8{~clr_flags}});
      ol_flag_r <= sense.ol | (ol_flag_r & {8{~clr_flags}});
      ov_r      <= sense.ov | (ov_r & ~clr_flags);
      uv_r      <= sense.uv | (uv_r & ~clr_flags);
      tsd_r     <= sense.thermal_trip_flag | (tsd_r & ~clr_flags);
      tw_r      <= sense.tw | (tw_r & ~clr_flags);
    end
  end

  // Standby exit start-up timer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r      <= PWR_STANDBY;
      act_prev_r <= 1'b0;
      su_cnt_r   <= 32'h0000_0000;
    end else begin
      act_prev_r <= syq_r[3];
      case (pwr_r)
        PWR_STANDBY: begin
          su_cnt_r <= 32'h0000_0000;
          if (syq_r[3] & ~act_prev_r) pwr_r <= PWR_STARTUP;
        end
        PWR_STARTUP: begin
          su_cnt_r <= su_cnt_r + 32'h0000_0001;
          if (!syq_r[3]) pwr_r <= PWR_STANDBY;
          else if (su_cnt_r == 32'(STARTUP_CYCLES - 1)) pwr_r <= PWR_ACTIVE;
        end
        PWR_ACTIVE: begin
          if (!syq_r[3]) pwr_r <= PWR_STANDBY;
        end
        default: pwr_r <= PWR_STANDBY;
      endcase
    end
  end
  assign nr_flag = (pwr_r == PWR_STARTUP);

  // Status words and fault summary
  always_comb begin
    stat = '0;
    stat.w0[S_ONE]          = 1'b1;
    stat.w0[S_OC +: NSTAGE] = oc_flag_r;
    stat.w1[S_ONE]          = 1'b1;
    stat.w1[S_OV]           = ov_r;
    stat.w1[S_UV]           = uv_r;
    stat.w1[S_TSD]          = tsd_r;
    stat.w1[S_TW]           = tw_r;
    stat.w1[S_NR]           = nr_flag;
    stat.w1[S_OL +: NSTAGE] = ol_flag_r;
    fault_free = ~(|stat.w0[14:1] | |stat.w1[14:S_NR]
                 | (|ol_flag_r & ~ctrl0_r[C_NOOL]));
    stat.w0[S_FF] = fault_free;
    stat.w1[S_FF] = fault_free;
  end

  // Copy for the link, frozen while a frame runs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= {16'h8000, 16'h8000};
    end else if (syq_r[0] & sy3_r[0]) begin
      hold_r <= stat;
    end
  end

  // Over-current retry pulse window
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 32'h0000_0000;
      phase_r    <= 3'h0;
    end else if (tick_cnt_r == 32'(RETRY_TICK - 1)) begin
      tick_cnt_r <= 32'h0000_0000;
      phase_r    <= phase_r + 3'h1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  assign retry_win = ctrl0_r[C_RATIO] ? (phase_r < 3'h2) : (phase_r == 3'h0);

  assign global_off = sense.ov | sense.uv
                    | (ctrl0_r[C_UVDIS] & (ov_r | uv_r))
                    | tsd_r | nr_flag;

  // Per-stage enable
  genvar k;
  generate
    for (k = 0; k < NSTAGE; k++) begin : g_stage
      localparam int OI = int'(STAGE_OUT[3*k +: 3]);
      assign want[k] = ctrl0_r[C_DRV + k]
                     & (~ctrl1_r[C_PWM + OI] | syq_r[1])
                     & (~oc_flag_r[k] | (ctrl1_r[C_REC + OI] & retry_win))
                     & ~global_off;
    end
    for (k = 0; k < NHB; k++) begin : g_bridge
      // Break before make: a side waits until its partner is seen off
      assign drv_nxt[2*k]   = want[2*k] & ~want[2*k+1] & ~drv_on_r[2*k+1];
      assign drv_nxt[2*k+1] = want[2*k+1] & ~want[2*k] & ~drv_on_r[2*k];
    end
  endgenerate
  assign drv_nxt[7:6] = want[7:6];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) drv_on_r <= 8'h00;
    else        drv_on_r <= drv_nxt;
  end
  assign stage_on = drv_on_r;

  // Monitor routing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cm_r <= 5'h00;
    else if (ctrl0_r[C_CM +: 3] > CM_LAST) cm_r <= 5'h00;
    else cm_r <= 5'(5'h01 << ctrl0_r[C_CM +: 3]);
  end
  assign current_image_out = cm_r;

  // ---------------- Checks ----------------
  sequence s_first_edge;
    !loaded_r ##1 loaded_r;
  endsequence

  property p_load;
    @(posedge spi_clk) disable iff (frame_select_n)
    s_first_edge |-> out_word_r == ($past(serial_in_pin) ? $past(hold_r.w1) : $past(hold_r.w0));
  endproperty
  a_load: assert property (p_load) else $error("status word not loaded at first edge");

  property p_oe;
    @(posedge core_clk) disable iff (!rst_n) serial_out_oe == !frame_select_n;
  endproperty
  a_oe: assert property (p_oe) else $error("serial output enable wrong");

  property p_commit;
    @(posedge core_clk) disable iff (!rst_n)
    commit0 |=> ctrl0_r == $past(shift_in_r);
  endproperty
  a_commit: assert property (p_commit) else $error("control word zero not committed");

  property p_discard;
    @(posedge core_clk) disable iff (!rst_n)
    (frame_end && cnt_r != FRAME_BITS) |=> $stable(ctrl0_r) && $stable(ctrl1_r);
  endproperty
  a_discard: assert property (p_discard) else $error("bad frame changed control");

  property p_clear;
    @(posedge core_clk) disable iff (!rst_n)
    (clr_flags && sense.oc == 8'h00 && !sense.thermal_trip_flag) |=> oc_flag_r == 8'h00 && !tsd_r;
  endproperty
  a_clear: assert property (p_clear) else $error("reset bit did not clear flags");

  property p_summary;
    @(posedge core_clk) disable iff (!rst_n)
    (oc_flag_r != 8'h00 || tsd_r) |-> !stat.w0[S_FF] && stat.w0[S_ONE] && stat.w1[S_ONE];
  endproperty
  a_summary: assert property (p_summary) else $error("fault summary or fixed bit wrong");

  property p_oc_off;
    @(posedge core_clk) disable iff (!rst_n)
    (oc_flag_r[7] && !ctrl1_r[C_REC + 4]) |=> !drv_on_r[7];
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("over-current stage still on");

  property p_tsd;
    @(posedge core_clk) disable iff (!rst_n) tsd_r |=> drv_on_r == 8'h00;
  endproperty
  a_tsd: assert property (p_tsd) else $error("stage on during thermal trip");

  property p_bridge;
    @(posedge core_clk) disable iff (!rst_n)
    !(drv_on_r[0] && drv_on_r[1]) && !(drv_on_r[2] && drv_on_r[3]) && !(drv_on_r[4] && drv_on_r[5]);
  endproperty
  a_bridge: assert property (p_bridge) else $error("half bridge cross conduction");

  property p_cm;
    @(posedge core_clk) disable iff (!rst_n) (ctrl0_r[C_CM +: 3] > CM_LAST) |=> cm_r == 5'h00;
  endproperty
  a_cm: assert property (p_cm) else $error("monitor routed for undefined code");

  property p_nr;
    @(posedge core_clk) disable iff (!rst_n) nr_flag |=> drv_on_r == 8'h00;
  endproperty
  a_nr: assert property (p_nr) else $error("stage on while not ready");
endmodule // drvspi_top
`default_nettype wire
